// [verilog/sdrc_pkg.sv]
// constants shared by the reclocker control and status block
package sdrc_pkg;

    // system clock and reference timing
    localparam int unsigned CLK_FREQ_MHZ   = 100;
    localparam int unsigned CLK_PERIOD_NS  = 10;
    localparam int unsigned REF_FREQ_MHZ   = 27;
    localparam int unsigned REF_PERIOD_NS  = 37;
    // one reference period as whole clock cycles, rounded up
    localparam int unsigned REF_PERIOD_CYC = (REF_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // longest time from an input change until lock drops
    localparam int unsigned LOCK_DROP_MAX_US  = 1000;
    localparam int unsigned LOCK_DROP_MAX_CYC = (LOCK_DROP_MAX_US * 1000 * 1000) / CLK_PERIOD_NS / 1000;
    // the requalify window spans the full lock drop time in milliseconds
    localparam int unsigned RELOCK_HOLD_MS    = 1;
    localparam int unsigned RELOCK_HOLD_CYC   = (RELOCK_HOLD_MS * 1000000) / CLK_PERIOD_NS;

    // apb register map, byte addresses
    localparam logic [11:0] CTRL_OFFSET   = 12'h000;
    localparam logic [11:0] STATUS_OFFSET = 12'h004;

    // control register fields
    localparam int unsigned CTRL_SW_MUTE_BIT   = 0;
    localparam int unsigned CTRL_SW_BYPASS_BIT = 1;
    localparam logic [1:0]  CTRL_RESET         = 2'h0;

    // status register fields
    localparam int unsigned STAT_LOCK_BIT     = 0;
    localparam int unsigned STAT_STD_RATE_BIT = 1;
    localparam int unsigned STAT_BYPASS_BIT   = 2;
    localparam int unsigned STAT_PRI_MUTE_BIT = 3;
    localparam int unsigned STAT_CLK_MODE_BIT = 4;
    localparam int unsigned STAT_RELOCK_BIT   = 5;

    // defaults applied by the internal pulls when a control pin floats
    localparam logic MUTE_N_PULL    = 1'b1;
    localparam logic BYPASS_PULL    = 1'b0;
    localparam logic CLK_SEL_PULL   = 1'b0;

    // levels held by a muted differential pair
    localparam logic MUTE_LEVEL_P   = 1'b0;
    localparam logic MUTE_LEVEL_N   = 1'b1;

    // lock qualification states
    typedef enum logic [0:0] {
        LK_TRACK  = 1'b0,
        LK_REQUAL = 1'b1
    } sdrc_lock_e;

endpackage

// [verilog/sdrc_ref_tick.sv]
// fractional divider giving one tick per reference clock period
`timescale 1ns/1ps

module sdrc_ref_tick #(
    parameter int unsigned CLK_MHZ = sdrc_pkg::CLK_FREQ_MHZ,
    parameter int unsigned REF_MHZ = sdrc_pkg::REF_FREQ_MHZ,
    parameter int unsigned ACC_W   = 8
) (
    input  wire logic clk_i,
    input  wire logic reset_n_i,
    input  wire logic ce_i,
    output logic      tick_o
);

    typedef struct packed {
        logic [ACC_W-1:0] acc;
        logic             tick;
    } sdrc_tick_s;

    localparam logic [ACC_W-1:0] STEP = ACC_W'(REF_MHZ);
    localparam logic [ACC_W-1:0] MODU = ACC_W'(CLK_MHZ);

    sdrc_tick_s st_q;
    sdrc_tick_s st_d;
    logic [ACC_W:0] sum;

    // phase accumulator: average tick rate is exactly ref over clk, jitter one cycle
    always_comb begin
        st_d = st_q;
        sum  = {1'b0, st_q.acc} + {1'b0, STEP};
        if (sum >= {1'b0, MODU}) begin
            st_d.acc  = ACC_W'(sum - {1'b0, MODU});
            st_d.tick = 1'b1;
        end else begin
            st_d.acc  = ACC_W'(sum);
            st_d.tick = 1'b0;
        end
    end

    // state register, frozen while the clock enable is low
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            st_q <= '0;
        end else if (ce_i) begin
            st_q <= st_d;
        end
    end

    assign tick_o = st_q.tick & ce_i;

endmodule // sdrc_ref_tick

// [verilog/sdrc_reclock_ctrl.sv]
// control and status logic of the serial video reclocker with apb registers
`timescale 1ns/1ps

// Functional notes
// - Mute input low mutes primary and second outputs in data or clock mode.
// - Mute wins over bypass and lock state.
// - Undriven mute input reads as high, outputs enabled.
// - Bypass input high passes raw input data without retiming.
// - Bypass low: bypass automatically when unlocked or rate unsupported.
// - Bypass input high keeps lock indicator low.
// - Undriven bypass input reads as low, automatic mode.
// - Lock 0 means bypassed; lock 1 with bypass 0 means retimed when the rate is supported, bypassed otherwise.
// - Lock may be tied to mute input, muting outputs while unlocked.
// - Standard-rate indicator high means locked at the supported rate.
// - Standard-rate indicator is registered, forced low while unlocked.
// - Standard-rate indicator settles within one reference period after lock rises, and clears on the next cycle after lock falls.
// - Input data change drops lock within a bounded time.
// - Clock select high gives recovered clock, low gives the primary data, retimed or raw when bypassed.
// - Undriven clock select reads as low, data on second output.
// - Both outputs are driven continuously, never tristated.
// - Lock high only with valid data present and pll locked.
// - Muted pair holds fixed opposite levels.
// - Second output in clock mode mutes while bypass is active.
// - Clock rising edge sits near the centre of each data bit.
module sdrc_reclock_ctrl #(
    parameter int unsigned RELOCK_HOLD_CYC = sdrc_pkg::RELOCK_HOLD_CYC,
    parameter int unsigned HOLD_W          = 17
) (
    input  wire logic        CLK_I,
    input  wire logic        RESET_N_I,
    input  wire logic        CE_I,
    // control pins, each with a flag telling whether the board drives it
    input  wire logic        MUTE_N_I,
    input  wire logic        MUTE_N_DRIVEN_I,
    input  wire logic        BYPASS_I,
    input  wire logic        BYPASS_DRIVEN_I,
    input  wire logic        CLOCK_OUT_SELECT_I,
    input  wire logic        CLOCK_OUT_SELECT_DRIVEN_I,
    // conditions from the analog clock recovery
    input  wire logic        PLL_LOCKED_I,
    input  wire logic        DATA_PRESENT_I,
    input  wire logic        RATE_SUPPORTED_I,
    input  wire logic        SIGNAL_CHANGE_I,
    // serial stream samples
    input  wire logic        SERIAL_IN_I,
    input  wire logic        RETIMED_DATA_I,
    input  wire logic        RECOVERED_CLK_I,
    // outputs
    output logic             PRIMARY_SERIAL_OUT_P_O,
    output logic             PRIMARY_SERIAL_OUT_N_O,
    output logic             SECOND_SERIAL_OUT_P_O,
    output logic             SECOND_SERIAL_OUT_N_O,
    output logic             PLL_LOCK_FLAG_PIN_O,
    output logic             STD_RATE_FLAG_O,
    // apb slave
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [11:0] PADDR,
    input  wire logic [31:0] PWDATA,
    output logic [31:0]      PRDATA,
    output logic             PREADY,
    output logic             PSLVERR
);

    typedef struct packed {
        logic [31:0]          rdata;
        logic                 sw_mute;
        logic                 sw_bypass;
        logic                 std_rate;
        sdrc_pkg::sdrc_lock_e lk_st;
        logic [HOLD_W-1:0]    hold_cnt;
        logic                 pri_p;
        logic                 pri_n;
        logic                 sec_p;
        logic                 sec_n;
    } sdrc_state_s;

    localparam logic [HOLD_W-1:0] HOLD_LAST = HOLD_W'(RELOCK_HOLD_CYC - 1);

    sdrc_state_s st_q;
    sdrc_state_s st_d;

    logic mute_n_eff;
    logic bypass_pin;
    logic clk_sel;
    logic relock_pend;
    logic lock_raw;
    logic bypass_act;
    logic mute_pri;
    logic mute_sec;
    logic ref_tick;
    logic apb_setup;
    logic apb_access;
    logic addr_hit;

    // floating pins take the level of their internal pull
    function automatic logic pin_level(input logic val, input logic driven, input logic pull);
        pin_level = driven ? val : pull;
    endfunction

    // address decode, used only for the error response
    function automatic logic reg_mapped(input logic [11:0] addr);
        reg_mapped = (addr == sdrc_pkg::CTRL_OFFSET) || (addr == sdrc_pkg::STATUS_OFFSET);
    endfunction

    // reference period timing, derived from the system clock
    sdrc_ref_tick u_ref_tick (
        .clk_i     (CLK_I),
        .reset_n_i (RESET_N_I),
        .ce_i      (CE_I),
        .tick_o    (ref_tick)
    );

    // pin resolution with pull defaults
    assign mute_n_eff = pin_level(MUTE_N_I, MUTE_N_DRIVEN_I, sdrc_pkg::MUTE_N_PULL);
    assign bypass_pin = pin_level(BYPASS_I, BYPASS_DRIVEN_I, sdrc_pkg::BYPASS_PULL)
                        | st_q.sw_bypass;
    assign clk_sel    = pin_level(CLOCK_OUT_SELECT_I, CLOCK_OUT_SELECT_DRIVEN_I,
                                  sdrc_pkg::CLK_SEL_PULL);

    // lock indicator: combinational so a board tie to the mute pin acts at once
    assign relock_pend = (st_q.lk_st == sdrc_pkg::LK_REQUAL);
    assign lock_raw    = PLL_LOCKED_I & DATA_PRESENT_I & ~relock_pend;
    assign PLL_LOCK_FLAG_PIN_O = lock_raw & ~bypass_pin;

    // bypass is forced by pin or taken automatically on lost lock or foreign rate
    assign bypass_act = bypass_pin | ~lock_raw | ~RATE_SUPPORTED_I;

    // mute has priority over bypass; a lock-to-mute tie mutes while unlocked
    assign mute_pri = ~mute_n_eff | st_q.sw_mute;
    assign mute_sec = mute_pri | (clk_sel & bypass_act);

    // apb phases; wait states only while the block is frozen
    assign apb_setup  = PSEL & ~PENABLE;
    assign apb_access = PSEL & PENABLE;
    assign addr_hit   = reg_mapped(PADDR);

    // next-state logic for lock qualification, indicator, outputs and registers
    always_comb begin
        st_d = st_q;

        // a data change holds lock low until the pll drops or the window ends
        unique case (st_q.lk_st)
            sdrc_pkg::LK_TRACK: begin
                st_d.hold_cnt = '0;
                if (SIGNAL_CHANGE_I) begin
                    st_d.lk_st = sdrc_pkg::LK_REQUAL;
                end
            end
            sdrc_pkg::LK_REQUAL: begin
                if (SIGNAL_CHANGE_I) begin
                    st_d.hold_cnt = '0;
                end else if (!PLL_LOCKED_I || st_q.hold_cnt == HOLD_LAST) begin
                    st_d.lk_st    = sdrc_pkg::LK_TRACK;
                    st_d.hold_cnt = '0;
                end else begin
                    st_d.hold_cnt = st_q.hold_cnt + HOLD_W'(1);
                end
            end
        endcase

        // rate flag samples once per reference period, cleared at once on unlock
        if (!PLL_LOCK_FLAG_PIN_O) begin
            st_d.std_rate = 1'b0;
        end else if (ref_tick) begin
            st_d.std_rate = RATE_SUPPORTED_I;
        end

        // primary pair: fixed opposite levels when muted, raw data when bypassed
        if (mute_pri) begin
            st_d.pri_p = sdrc_pkg::MUTE_LEVEL_P;
        end else if (bypass_act) begin
            st_d.pri_p = SERIAL_IN_I;
        end else begin
            st_d.pri_p = RETIMED_DATA_I;
        end
        st_d.pri_n = mute_pri ? sdrc_pkg::MUTE_LEVEL_N : ~st_d.pri_p;

        // second pair: recovered clock when selected, else data; clock already centred on the bit by the cdr
        if (mute_sec) begin
            st_d.sec_p = sdrc_pkg::MUTE_LEVEL_P;
        end else if (clk_sel) begin
            st_d.sec_p = RECOVERED_CLK_I;
        end else if (bypass_act) begin
            st_d.sec_p = SERIAL_IN_I;
        end else begin
            st_d.sec_p = RETIMED_DATA_I;
        end
        st_d.sec_n = mute_sec ? sdrc_pkg::MUTE_LEVEL_N : ~st_d.sec_p;

        // read data is captured in setup so it comes from a flop in access
        if (apb_setup) begin
            st_d.rdata = '0;
            if (PADDR == sdrc_pkg::CTRL_OFFSET) begin
                st_d.rdata[sdrc_pkg::CTRL_SW_MUTE_BIT]   = st_q.sw_mute;
                st_d.rdata[sdrc_pkg::CTRL_SW_BYPASS_BIT] = st_q.sw_bypass;
            end else if (PADDR == sdrc_pkg::STATUS_OFFSET) begin
                st_d.rdata[sdrc_pkg::STAT_LOCK_BIT]     = PLL_LOCK_FLAG_PIN_O;
                st_d.rdata[sdrc_pkg::STAT_STD_RATE_BIT] = st_q.std_rate;
                st_d.rdata[sdrc_pkg::STAT_BYPASS_BIT]   = bypass_act;
                st_d.rdata[sdrc_pkg::STAT_PRI_MUTE_BIT] = mute_pri;
                st_d.rdata[sdrc_pkg::STAT_CLK_MODE_BIT] = clk_sel;
                st_d.rdata[sdrc_pkg::STAT_RELOCK_BIT]   = relock_pend;
            end
        end

        // writes land in the access phase; status is read only
        if (apb_access && PWRITE && PADDR == sdrc_pkg::CTRL_OFFSET) begin
            st_d.sw_mute   = PWDATA[sdrc_pkg::CTRL_SW_MUTE_BIT];
            st_d.sw_bypass = PWDATA[sdrc_pkg::CTRL_SW_BYPASS_BIT];
        end
    end

    // single state register; the clock enable freezes everything
    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            st_q           <= '0;
            st_q.sw_mute   <= sdrc_pkg::CTRL_RESET[sdrc_pkg::CTRL_SW_MUTE_BIT];
            st_q.sw_bypass <= sdrc_pkg::CTRL_RESET[sdrc_pkg::CTRL_SW_BYPASS_BIT];
            st_q.lk_st     <= sdrc_pkg::LK_TRACK;
            st_q.pri_n     <= sdrc_pkg::MUTE_LEVEL_N;
            st_q.sec_n     <= sdrc_pkg::MUTE_LEVEL_N;
        end else if (CE_I) begin
            st_q <= st_d;
        end
    end

    // outputs
    assign PRIMARY_SERIAL_OUT_P_O = st_q.pri_p;
    assign PRIMARY_SERIAL_OUT_N_O = st_q.pri_n;
    assign SECOND_SERIAL_OUT_P_O  = st_q.sec_p;
    assign SECOND_SERIAL_OUT_N_O  = st_q.sec_n;
    assign STD_RATE_FLAG_O        = st_q.std_rate;
    assign PRDATA                 = st_q.rdata;
    // frozen block stalls the bus rather than drop a write
    assign PREADY                 = CE_I;
    assign PSLVERR                = apb_access & ~addr_hit;

    // checks on the control behaviour
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RESET_N_I);

    a_mute_primary: assert property ((mute_pri && CE_I) |=> (!PRIMARY_SERIAL_OUT_P_O && PRIMARY_SERIAL_OUT_N_O))
        else $error("primary pair not muted");
    a_mute_over_bypass: assert property ((!mute_n_eff && bypass_pin && CE_I) |=> (!SECOND_SERIAL_OUT_P_O && SECOND_SERIAL_OUT_N_O))
        else $error("mute did not override bypass");
    a_float_mute_on: assert property ((!MUTE_N_DRIVEN_I && !st_q.sw_mute && CE_I)
        |=> PRIMARY_SERIAL_OUT_P_O == ($past(bypass_act) ? $past(SERIAL_IN_I) : $past(RETIMED_DATA_I)))
        else $error("floating mute pin muted outputs");
    a_bypass_raw: assert property ((bypass_pin && !mute_pri && CE_I) |=> PRIMARY_SERIAL_OUT_P_O == $past(SERIAL_IN_I))
        else $error("bypass did not pass raw data");
    a_retime_locked: assert property ((PLL_LOCK_FLAG_PIN_O && RATE_SUPPORTED_I && !mute_pri && CE_I) |=> PRIMARY_SERIAL_OUT_P_O == $past(RETIMED_DATA_I))
        else $error("locked output not retimed");
    a_auto_bypass: assert property ((!bypass_pin && !lock_raw && !mute_pri && CE_I) |=> PRIMARY_SERIAL_OUT_P_O == $past(SERIAL_IN_I))
        else $error("unlocked output not bypassed");
    a_lock_low_bypass: assert property (bypass_pin |-> !PLL_LOCK_FLAG_PIN_O)
        else $error("lock high under forced bypass");
    a_lock_needs_pll: assert property (PLL_LOCK_FLAG_PIN_O |-> (PLL_LOCKED_I && DATA_PRESENT_I))
        else $error("lock without pll and data");
    a_std_low_unlock: assert property ((!PLL_LOCK_FLAG_PIN_O && CE_I) |=> !STD_RATE_FLAG_O)
        else $error("rate flag high while unlocked");
    a_std_settle: assert property ((PLL_LOCK_FLAG_PIN_O && RATE_SUPPORTED_I && CE_I) [*5] |-> STD_RATE_FLAG_O)
        else $error("rate flag late after lock");
    a_std_rise_tick: assert property ($rose(STD_RATE_FLAG_O) |-> $past(ref_tick) && $past(PLL_LOCK_FLAG_PIN_O))
        else $error("rate flag rose off a reference tick");
    a_change_drops: assert property ((SIGNAL_CHANGE_I && CE_I) |=> !PLL_LOCK_FLAG_PIN_O)
        else $error("lock held after data change");
    a_second_clock: assert property ((clk_sel && !mute_sec && CE_I) |=> SECOND_SERIAL_OUT_P_O == $past(RECOVERED_CLK_I))
        else $error("second output not clock");
    a_clock_bypass_mute: assert property ((clk_sel && bypass_act && CE_I) |=> (!SECOND_SERIAL_OUT_P_O && SECOND_SERIAL_OUT_N_O))
        else $error("clock not muted in bypass");
    a_pairs_driven: assert property ((PRIMARY_SERIAL_OUT_N_O != PRIMARY_SERIAL_OUT_P_O) && (SECOND_SERIAL_OUT_N_O != SECOND_SERIAL_OUT_P_O))
        else $error("pair lines not opposite");

    c_locked_retime: cover property (PLL_LOCK_FLAG_PIN_O && STD_RATE_FLAG_O && !mute_pri);
    c_change_relock: cover property (SIGNAL_CHANGE_I ##1 relock_pend [*8]);
    c_clock_mode: cover property (clk_sel && !mute_sec && RECOVERED_CLK_I);
    c_apb_write: cover property (apb_access && PWRITE && addr_hit && PREADY);

endmodule // sdrc_reclock_ctrl

// [verification/sdrc_cdr_model.sv]
// model of the cable equalizer and clock recovery that feed the reclocker control block
`timescale 1ns/1ps

module sdrc_cdr_model (
    input  wire logic clk_i,
    input  wire logic reset_n_i,
    input  wire logic present_i,
    input  wire logic rate_i,
    input  wire logic slow_i,
    output logic      pll_locked_o,
    output logic      data_present_o,
    output logic      rate_supported_o,
    output logic      serial_in_o,
    output logic      retimed_o,
    output logic      rclk_o
);
    int acq;

    // lock comes only after a run of valid data, slow or prompt; it drops at once when the cable goes quiet
    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            acq <= 0;
            pll_locked_o <= 1'b0;
            data_present_o <= 1'b0;
            rate_supported_o <= 1'b0;
            serial_in_o <= 1'b0;
            retimed_o <= 1'b0;
            rclk_o <= 1'b0;
        end else begin
            acq <= present_i ? acq + 1 : 0;  // acquisition counted in system clock cycles
            pll_locked_o <= present_i && acq >= (slow_i ? 12 : 4);
            data_present_o <= present_i;
            rate_supported_o <= rate_i;
            // a quiet line must not look like steady data, so it toggles
            serial_in_o <= present_i ? 1'($urandom) : ~serial_in_o;
            retimed_o <= serial_in_o;
            rclk_o <= ~rclk_o;
        end
    end
endmodule // sdrc_cdr_model

// [verification/testbench.sv]
// self-checking bench of the reclocker control and status block
`timescale 1ns/1ps

module testbench;
    localparam int unsigned HOLD = 20;
    logic        CLK_I, RESET_N_I, CE_I, MUTE_N_DRIVEN_I, BYPASS_I, BYPASS_DRIVEN_I;
    logic        CLOCK_OUT_SELECT_I, CLOCK_OUT_SELECT_DRIVEN_I, SIGNAL_CHANGE_I, PSEL, PENABLE, PWRITE;
    logic [11:0] PADDR;
    logic [31:0] PWDATA;
    wire  logic  MUTE_N_I, PLL_LOCKED_I, DATA_PRESENT_I, RATE_SUPPORTED_I, SERIAL_IN_I, RETIMED_DATA_I;
    wire  logic  RECOVERED_CLK_I, PRIMARY_SERIAL_OUT_P_O, PRIMARY_SERIAL_OUT_N_O, SECOND_SERIAL_OUT_P_O;
    wire  logic  SECOND_SERIAL_OUT_N_O, PLL_LOCK_FLAG_PIN_O, STD_RATE_FLAG_O, PREADY, PSLVERR;
    wire  logic [31:0] PRDATA;
    logic        mute_n, tie, present, rate, slow, rel, lock_prev, rprev, std_exp, ep, es, armed;
    logic [1:0]  ctrl_m;
    logic [3:0]  v, vn;
    int          rc, guard, run, err_total, samples_checked;

    // board tie of lock flag to mute input
    assign MUTE_N_I = tie ? PLL_LOCK_FLAG_PIN_O : mute_n;

    sdrc_reclock_ctrl #(.RELOCK_HOLD_CYC(HOLD), .HOLD_W(17)) i_dut (
        .CLK_I, .RESET_N_I, .CE_I, .MUTE_N_I, .MUTE_N_DRIVEN_I, .BYPASS_I, .BYPASS_DRIVEN_I,
        .CLOCK_OUT_SELECT_I, .CLOCK_OUT_SELECT_DRIVEN_I, .PLL_LOCKED_I, .DATA_PRESENT_I,
        .RATE_SUPPORTED_I, .SIGNAL_CHANGE_I, .SERIAL_IN_I, .RETIMED_DATA_I, .RECOVERED_CLK_I,
        .PRIMARY_SERIAL_OUT_P_O, .PRIMARY_SERIAL_OUT_N_O, .SECOND_SERIAL_OUT_P_O, .SECOND_SERIAL_OUT_N_O,
        .PLL_LOCK_FLAG_PIN_O, .STD_RATE_FLAG_O, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA,
        .PREADY, .PSLVERR);

    sdrc_cdr_model i_cdr (.clk_i(CLK_I), .reset_n_i(RESET_N_I), .present_i(present), .rate_i(rate),
        .slow_i(slow), .pll_locked_o(PLL_LOCKED_I), .data_present_o(DATA_PRESENT_I),
        .rate_supported_o(RATE_SUPPORTED_I), .serial_in_o(SERIAL_IN_I), .retimed_o(RETIMED_DATA_I),
        .rclk_o(RECOVERED_CLK_I));

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        samples_checked++;
        if (s !== e) begin
            err_total++;
            $display("BAD %s expected %h seen %h", nm, e, s);
        end
    endtask

    // apb master, entered just after a rising edge; waits for pready under a bound
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        int n;
        PSEL <= 1'b1;
        PENABLE <= 1'b0;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge CLK_I);
        PENABLE <= 1'b1;
        n = 0;
        do begin
            @(posedge CLK_I);
            n++;
        end while (PREADY !== 1'b1 && n < 50);
        if (n >= 50) begin
            err_total++;
            final_report();
        end
        r = PRDATA;
        e = PSLVERR;
        if (w && !e && a == sdrc_pkg::CTRL_OFFSET) begin
            ctrl_m <= d[1:0];
        end
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
        // one idle edge so a following call never reassigns psel in this time step
        @(posedge CLK_I);
    endtask

    // reference model: {lock, bypass active, primary mute, second mute} from present inputs
    function automatic logic [3:0] ev();
        logic bpin, lraw, lk, mn, mp, cs, bact;
        bpin = (BYPASS_DRIVEN_I & BYPASS_I) | ctrl_m[1];
        lraw = PLL_LOCKED_I & DATA_PRESENT_I & !rel;
        lk = lraw & !bpin;
        mn = MUTE_N_DRIVEN_I ? (tie ? lk : mute_n) : 1'b1;
        mp = !mn | ctrl_m[0];
        cs = CLOCK_OUT_SELECT_DRIVEN_I & CLOCK_OUT_SELECT_I;
        bact = bpin | !lraw | !RATE_SUPPORTED_I;
        return {lk, bact, mp, mp | (cs & bact)};
    endfunction

    // next registered outputs from the values seen at this edge; requalify tracked here too
    always @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            {rel, lock_prev, rprev, std_exp, ep, es, armed} = '0;
            {rc, guard, run} = '0;
        end else begin
            v = ev();
            ep = v[1] ? 1'b0 : (v[2] ? SERIAL_IN_I : RETIMED_DATA_I);
            es = v[0] ? 1'b0 : ((CLOCK_OUT_SELECT_DRIVEN_I & CLOCK_OUT_SELECT_I) ? RECOVERED_CLK_I : ep);
            run = (v[3] && RATE_SUPPORTED_I === rprev) ? run + 1 : 0;
            rprev = RATE_SUPPORTED_I;
            lock_prev = v[3];
            std_exp = RATE_SUPPORTED_I;
            guard = guard > 0 ? guard - 1 : 0;
            if (SIGNAL_CHANGE_I) begin
                rel = 1'b1;
                rc = 0;
            end else if (rel && (!PLL_LOCKED_I || rc >= HOLD - 1)) begin
                rel = 1'b0;
                guard = 3;
            end else if (rel) begin
                rc++;
            end
            armed = 1'b1;
        end
    end

    // compare every cycle; requalify ends after HOLD cycles or when the pll drops, a short guard follows it
    always @(negedge CLK_I) begin
        if (RESET_N_I && armed && guard == 0) begin
            vn = ev();
            chk("lock", vn[3], PLL_LOCK_FLAG_PIN_O);
            chk("pri_p", ep, PRIMARY_SERIAL_OUT_P_O);
            chk("pri_n", !ep, PRIMARY_SERIAL_OUT_N_O);
            chk("sec_p", es, SECOND_SERIAL_OUT_P_O);
            chk("sec_n", !es, SECOND_SERIAL_OUT_N_O);
            if (!lock_prev) begin
                chk("std_low", 1'b0, STD_RATE_FLAG_O);
            end else if (run >= 6) begin
                chk("std_rate", std_exp, STD_RATE_FLAG_O);
            end
        end
    end

    initial begin
        CLK_I = 1'b0;
        forever #5 CLK_I = ~CLK_I;
    end

    initial begin
        repeat (20000) @(posedge CLK_I);
        err_total++;
        final_report();
    end

    initial begin : main
        logic [31:0] rd;
        logic        er;
        int          i;
        i = $urandom(32'hb753);
        {RESET_N_I, MUTE_N_DRIVEN_I, BYPASS_I, BYPASS_DRIVEN_I, CLOCK_OUT_SELECT_I} = '0;
        {CLOCK_OUT_SELECT_DRIVEN_I, SIGNAL_CHANGE_I, PSEL, PENABLE, PWRITE, tie, present, rate, slow} = '0;
        {PADDR, PWDATA, ctrl_m, err_total, samples_checked} = '0;
        CE_I = 1'b1;
        mute_n = 1'b1;
        repeat (3) @(posedge CLK_I);
        RESET_N_I <= 1'b1;
        // all control pins floating: unmuted, automatic bypass, data on second output
        present <= 1'b1;
        rate <= 1'b1;
        repeat (30) @(posedge CLK_I);
        chk("lock_float", 1'b1, PLL_LOCK_FLAG_PIN_O);
        for (i = 0; i < 40; i++) begin
            {mute_n, MUTE_N_DRIVEN_I, BYPASS_I, BYPASS_DRIVEN_I, CLOCK_OUT_SELECT_I,
             CLOCK_OUT_SELECT_DRIVEN_I, present, rate, slow} <= 9'($urandom);
            repeat (16) @(posedge CLK_I);
        end
        {mute_n, MUTE_N_DRIVEN_I, BYPASS_DRIVEN_I, CLOCK_OUT_SELECT_DRIVEN_I, present, rate} <= 6'h3f;
        {BYPASS_I, CLOCK_OUT_SELECT_I, slow} <= 3'h0;
        repeat (30) @(posedge CLK_I);
        // data change, then a second change mid-count restarts the requalify
        for (i = 0; i < 2; i++) begin
            SIGNAL_CHANGE_I <= 1'b1;
            @(posedge CLK_I);
            SIGNAL_CHANGE_I <= 1'b0;
            repeat (10) @(posedge CLK_I);
        end
        repeat (5) @(posedge CLK_I);
        chk("lock_requal", 1'b0, PLL_LOCK_FLAG_PIN_O);
        repeat (20) @(posedge CLK_I);
        chk("lock_back", 1'b1, PLL_LOCK_FLAG_PIN_O);
        // lock tied to mute: cable loss mutes both outputs
        tie <= 1'b1;
        present <= 1'b0;
        repeat (10) @(posedge CLK_I);
        chk("tie_mute", 2'h1, {SECOND_SERIAL_OUT_P_O, SECOND_SERIAL_OUT_N_O});
        present <= 1'b1;
        repeat (30) @(posedge CLK_I);
        tie <= 1'b0;
        repeat (10) @(posedge CLK_I);
        apb(1'b0, sdrc_pkg::CTRL_OFFSET, 32'h0, rd, er);
        chk("ctrl_reset", 32'(sdrc_pkg::CTRL_RESET), rd);
        apb(1'b1, sdrc_pkg::CTRL_OFFSET, 32'h3, rd, er);
        apb(1'b0, sdrc_pkg::CTRL_OFFSET, 32'h0, rd, er);
        chk("ctrl_rd", 32'h3, rd);
        repeat (10) @(posedge CLK_I);
        apb(1'b0, sdrc_pkg::STATUS_OFFSET, 32'h0, rd, er);
        chk("stat_sw", (32'h1 << sdrc_pkg::STAT_PRI_MUTE_BIT) | (32'h1 << sdrc_pkg::STAT_BYPASS_BIT), rd);
        apb(1'b1, sdrc_pkg::CTRL_OFFSET, 32'h0, rd, er);
        apb(1'b1, sdrc_pkg::STATUS_OFFSET, 32'hff, rd, er);
        chk("stat_wr_err", 1'b0, er);
        repeat (12) @(posedge CLK_I);
        apb(1'b0, sdrc_pkg::STATUS_OFFSET, 32'h0, rd, er);
        chk("stat_run", (32'h1 << sdrc_pkg::STAT_LOCK_BIT) | (32'h1 << sdrc_pkg::STAT_STD_RATE_BIT), rd);
        apb(1'b1, 12'h008, 32'h3, rd, er);
        chk("unmapped_err", 1'b1, er);
        apb(1'b0, 12'h008, 32'h0, rd, er);
        chk("unmapped_rd_err", 1'b1, er);
        chk("unmapped_rd", 32'h0, rd);
        apb(1'b0, sdrc_pkg::CTRL_OFFSET, 32'h0, rd, er);
        chk("ctrl_kept", 32'h0, rd);
        repeat (5) @(posedge CLK_I);
        final_report();
    end
endmodule // testbench
